// *** sdram_timing_idle_config.sv ***
/*
  SDRAM timing and idle configuration: register file on AXI4-Lite,
  command spacing, periodic refresh, lateness interrupt and the
  command, bank and address pins with their idle values.
  Assumes the user command port and the pins share aclk.
*/
`timescale 1ns/1ns
`include "sdram_cfg_regs.svh"
module sdram_timing_idle_config (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [15:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [15:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire sdram_cfg_pkg::mem_op_e cmd_op,
  input wire logic [1:0] cmd_bank,
  input wire logic [11:0] cmd_addr,
  output logic mem_column_strobe_n,
  output logic mem_row_strobe_n,
  output logic mem_write_strobe_n,
  output logic [1:0] mem_bank_select,
  output logic [11:0] mem_address_bus,
  output logic read_capture,
  output logic irq
);
  sdram_cfg_pkg::ctrl_s st_ff;
  sdram_cfg_pkg::ctrl_s nxt_st;
  logic wr_go;
  logic [13:0] wr_idx;
  logic [15:0] wr_data;
  logic [1:0] wr_be;
  logic wr_hit;
  logic rd_go;
  logic [13:0] rd_idx;
  logic [15:0] rd_data;
  logic rd_hit;
  logic en;
  logic ref_req;
  logic late_event;
  logic [3:0] rc_dly;
  logic [3:0] cp_dly;
  logic [3:0] pc_dly;
  logic [3:0] rs_dly;
  logic [11:0] col_mask;
  logic pre_ok;
  logic issue_ref;
  logic issue_user;
  logic [3:0] issue_kind;

  // merge a bus write into a register through lanes and writable bits
  function automatic logic [15:0] merge16(
    input logic [15:0] old,
    input logic [15:0] data,
    input logic [1:0] be,
    input logic [15:0] wmask
  );
    logic [15:0] lanes;
    lanes = {{8{be[1]}}, {8{be[0]}}} & wmask;
    merge16 = (old & ~lanes) | (data & lanes);
  endfunction

  // two-bit spacing code, zero stands for four cycles
  function automatic logic [3:0] dly4(input logic [1:0] code);
    dly4 = (code == 2'h0) ? `DLY_CODE0 : {2'h0, code};
  endfunction

  sdram_cfg_axil u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .wr_go(wr_go),
    .wr_idx(wr_idx),
    .wr_data(wr_data),
    .wr_be(wr_be),
    .wr_hit(wr_hit),
    .rd_go(rd_go),
    .rd_idx(rd_idx),
    .rd_data(rd_data),
    .rd_hit(rd_hit)
  );

  sdram_refresh_track u_refresh (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(en),
    .interval(st_ff.ref_interval),
    .late_limit(st_ff.late_limit),
    .refresh_done(issue_ref),
    .refresh_req(ref_req),
    .pending_count(),
    .late_event(late_event)
  );

  assign en = st_ff.ctrl[`CTL_EN];

  // register map decode for writes and reads
  always_comb begin
    wr_hit = 1'b1;
    case (wr_idx)
      `IDX_CONTROL, `IDX_INT_STATUS, `IDX_INT_MASK, `IDX_GEOMETRY,
      `IDX_REF_INTERVAL, `IDX_LATE_LIMIT, `IDX_IDLE_CMD,
      `IDX_IDLE_ADDR: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
    rd_hit = 1'b1;
    case (rd_idx)
      `IDX_CONTROL: rd_data = st_ff.ctrl;
      `IDX_INT_STATUS: rd_data = st_ff.int_status;
      `IDX_INT_MASK: rd_data = st_ff.int_mask;
      `IDX_GEOMETRY: rd_data = st_ff.geometry;
      `IDX_REF_INTERVAL: rd_data = st_ff.ref_interval;
      `IDX_LATE_LIMIT: rd_data = st_ff.late_limit;
      `IDX_IDLE_CMD: rd_data = st_ff.idle_cmd;
      `IDX_IDLE_ADDR: rd_data = st_ff.idle_addr;
      default: begin
        rd_data = 16'h0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  // spacing and geometry decode
  always_comb begin
    rc_dly = st_ff.geometry[`GEO_RC_HI:`GEO_RC_LO] == 2'h1 ? `RC_CODE1 :
      dly4(st_ff.geometry[`GEO_RC_HI:`GEO_RC_LO]);
    cp_dly = dly4(st_ff.geometry[`GEO_CP_HI:`GEO_CP_LO]);
    pc_dly = dly4(st_ff.geometry[`GEO_PC_HI:`GEO_PC_LO]);
    case (st_ff.geometry[`GEO_RS_HI:`GEO_RS_LO])
      2'h2: rs_dly = `RS_CODE2;
      2'h3: rs_dly = `RS_CODE3;
      default: rs_dly = `RS_CODE0;
    endcase
    case (st_ff.geometry[`GEO_COL_HI:`GEO_COL_LO])
      2'h1: col_mask = `COLMASK_512;
      2'h2: col_mask = `COLMASK_1024;
      default: col_mask = `COLMASK_256;
    endcase
  end

  // command admission: refresh first, user only when spacing allows
  always_comb begin
    pre_ok = st_ff.gap[2] >= pc_dly;
    issue_ref = en && ref_req && pre_ok && !st_ff.row_open &&
      st_ff.gap[3] >= rs_dly;
    cmd_ready = 1'b0;
    if (en && pre_ok && !issue_ref) begin
      case (cmd_op)
        sdram_cfg_pkg::op_activate:
          cmd_ready = !st_ff.row_open && !ref_req;
        sdram_cfg_pkg::op_read, sdram_cfg_pkg::op_write:
          cmd_ready = st_ff.row_open && st_ff.gap[0] >= rc_dly;
        sdram_cfg_pkg::op_precharge:
          cmd_ready = st_ff.row_open && st_ff.gap[1] >= cp_dly;
        default: cmd_ready = 1'b0;
      endcase
    end
    issue_user = cmd_valid && cmd_ready;
    issue_kind[0] = issue_user && cmd_op == sdram_cfg_pkg::op_activate;
    issue_kind[1] = issue_user && (cmd_op == sdram_cfg_pkg::op_read ||
      cmd_op == sdram_cfg_pkg::op_write);
    issue_kind[2] = issue_user && cmd_op == sdram_cfg_pkg::op_precharge;
    issue_kind[3] = issue_ref;
  end

  // next state: registers, status, spacing counters and pins
  always_comb begin
    nxt_st = st_ff;
    if (wr_go) begin
      case (wr_idx)
        `IDX_CONTROL: nxt_st.ctrl =
          merge16(st_ff.ctrl, wr_data, wr_be, `MASK_CONTROL);
        `IDX_INT_MASK: nxt_st.int_mask =
          merge16(st_ff.int_mask, wr_data, wr_be, `MASK_INT);
        `IDX_GEOMETRY: nxt_st.geometry =
          merge16(st_ff.geometry, wr_data, wr_be, `MASK_GEOMETRY);
        `IDX_REF_INTERVAL: nxt_st.ref_interval =
          merge16(st_ff.ref_interval, wr_data, wr_be, 16'hFFFF);
        `IDX_LATE_LIMIT: nxt_st.late_limit =
          merge16(st_ff.late_limit, wr_data, wr_be, 16'hFFFF);
        `IDX_IDLE_CMD: nxt_st.idle_cmd =
          merge16(st_ff.idle_cmd, wr_data, wr_be, `MASK_IDLE_CMD);
        `IDX_IDLE_ADDR: nxt_st.idle_addr =
          merge16(st_ff.idle_addr, wr_data, wr_be, `MASK_IDLE_ADDR);
        default: nxt_st.ctrl = st_ff.ctrl;
      endcase
    end
    // read of status clears it, a new event in that cycle still lands
    if (rd_go && rd_idx == `IDX_INT_STATUS) begin
      nxt_st.int_status = 16'h0000;
    end
    if (late_event) begin
      nxt_st.int_status[`STS_LATE] = 1'b1;
    end
    nxt_st.irq = |(nxt_st.int_status & nxt_st.int_mask);
    // cycles since each command kind, saturating
    for (int i = 0; i < 4; i++) begin
      if (issue_kind[i]) begin
        nxt_st.gap[i] = 4'h0;
      end else if (st_ff.gap[i] != `GAP_SAT) begin
        nxt_st.gap[i] = st_ff.gap[i] + 4'h1;
      end
    end
    if (issue_kind[0]) begin
      nxt_st.row_open = 1'b1;
    end else if (issue_kind[2]) begin
      nxt_st.row_open = 1'b0;
    end
    nxt_st.rd_pipe = {st_ff.rd_pipe[1:0],
      issue_user && cmd_op == sdram_cfg_pkg::op_read};
    nxt_st.live = en;
    // pins: idle values while disabled, no-op or command while enabled
    if (!en) begin
      nxt_st.cas_n = st_ff.idle_cmd[`IDL_CAS];
      nxt_st.ras_n = st_ff.idle_cmd[`IDL_RAS];
      nxt_st.we_n = st_ff.idle_cmd[`IDL_WE];
      nxt_st.bs = st_ff.idle_cmd[`IDL_BS_HI:`IDL_BS_LO];
      nxt_st.addr = st_ff.idle_addr[`IDL_ADDR_HI:0];
    end else begin
      nxt_st.cas_n = 1'b1;
      nxt_st.ras_n = 1'b1;
      nxt_st.we_n = 1'b1;
      if (issue_ref) begin
        nxt_st.cas_n = 1'b0;
        nxt_st.ras_n = 1'b0;
      end else if (issue_user) begin
        nxt_st.bs = cmd_bank;
        nxt_st.addr = cmd_addr;
        case (cmd_op)
          sdram_cfg_pkg::op_activate: nxt_st.ras_n = 1'b0;
          sdram_cfg_pkg::op_read: begin
            nxt_st.cas_n = 1'b0;
            nxt_st.addr = cmd_addr & col_mask;
          end
          sdram_cfg_pkg::op_write: begin
            nxt_st.cas_n = 1'b0;
            nxt_st.we_n = 1'b0;
            nxt_st.addr = cmd_addr & col_mask;
          end
          default: begin
            nxt_st.ras_n = 1'b0;
            nxt_st.we_n = 1'b0;
          end
        endcase
      end
    end
    if (!aresetn) begin
      nxt_st = '0;
      nxt_st.ctrl = `RST_CONTROL;
      nxt_st.geometry = `RST_GEOMETRY;
      nxt_st.ref_interval = `RST_REF_INTERVAL;
      nxt_st.late_limit = `RST_LATE_LIMIT;
      nxt_st.idle_cmd = `RST_IDLE_CMD;
      nxt_st.idle_addr = `RST_IDLE_ADDR;
      nxt_st.cas_n = 1'b1;
      nxt_st.ras_n = 1'b1;
      nxt_st.we_n = 1'b1;
      nxt_st.bs = 2'h3;
      nxt_st.gap = {4{`GAP_SAT}};
    end
  end

  // state register
  always_ff @(posedge aclk) begin
    st_ff <= nxt_st;
  end

  // outputs straight from state
  assign mem_column_strobe_n = st_ff.cas_n;
  assign mem_row_strobe_n = st_ff.ras_n;
  assign mem_write_strobe_n = st_ff.we_n;
  assign mem_bank_select = st_ff.bs;
  assign mem_address_bus = st_ff.addr;
  assign read_capture = st_ff.geometry[`GEO_CL] ?
    st_ff.rd_pipe[2] : st_ff.rd_pipe[1];
  assign irq = st_ff.irq;

  // pin decode for the checks below
  logic pin_act;
  logic pin_col;
  logic pin_pre;
  logic pin_ref;
  logic pin_rd;
  assign pin_act = st_ff.live && !st_ff.ras_n && st_ff.cas_n && st_ff.we_n;
  assign pin_col = st_ff.live && st_ff.ras_n && !st_ff.cas_n;
  assign pin_pre = st_ff.live && !st_ff.ras_n && st_ff.cas_n && !st_ff.we_n;
  assign pin_ref = st_ff.live && !st_ff.ras_n && !st_ff.cas_n && st_ff.we_n;
  assign pin_rd = pin_col && st_ff.we_n;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  idle_strobes_a: assert property ($past(aresetn) && !$past(en) |->
    {mem_write_strobe_n, mem_row_strobe_n, mem_column_strobe_n} ==
    $past(st_ff.idle_cmd[2:0]))
    else $error("idle strobes differ from idle bits");
  idle_bank_a: assert property ($past(aresetn) && !$past(en) |->
    mem_bank_select == $past(st_ff.idle_cmd[4:3]))
    else $error("idle bank select differs from idle field");
  idle_addr_a: assert property ($past(aresetn) && !$past(en) |->
    mem_address_bus == $past(st_ff.idle_addr[11:0]))
    else $error("idle address differs from idle field");
  enable_gate_a: assert property (!en |-> !cmd_ready && !issue_ref)
    else $error("command admitted while disabled");
  row_col_gap_a: assert property (pin_act |=> !pin_col [*2])
    else $error("column strobe too soon after activate");
  col_pre_gap_a: assert property (pin_col && cp_dly == 4'h4 |=>
    !pin_pre [*4])
    else $error("precharge too soon after column strobe");
  pre_cmd_gap_a: assert property (pin_pre && pc_dly == 4'h2 |=>
    !(pin_act || pin_col || pin_pre || pin_ref) [*2])
    else $error("command too soon after precharge");
  ref_space_a: assert property (pin_ref && rs_dly == 4'h3 |=>
    !pin_ref [*3])
    else $error("refresh too soon after refresh");
  cas_lat_a: assert property (pin_rd && st_ff.geometry[2] |->
    !read_capture ##2 read_capture)
    else $error("read capture not at latency three");
  col_mask_a: assert property (pin_col |->
    mem_address_bus[11:10] == 2'h0 &&
    (mem_address_bus[9] == 1'b0 || st_ff.geometry[1:0] == 2'h2) &&
    (mem_address_bus[8] == 1'b0 || st_ff.geometry[0] != st_ff.geometry[1]))
    else $error("column address exceeds the column count");
  late_irq_a: assert property (late_event && st_ff.int_mask[0] |=>
    irq && st_ff.int_status[0])
    else $error("late refresh did not raise interrupt");
  ref_issue_a: assert property (en && ref_req && !st_ff.row_open &&
    st_ff.gap[2] == 4'hF && st_ff.gap[3] == 4'hF |=> pin_ref)
    else $error("pending refresh not issued");

  refresh_seen_c: cover property (pin_ref ##[1:40] pin_ref);
  read_seen_c: cover property (pin_act ##[2:8] pin_rd ##[1:8] pin_pre);
  late_seen_c: cover property (late_event ##1 irq);
endmodule

// *** sdram_cfg_regs.svh ***
/*
  Register indexes, field positions, reset values and delay codes of
  the SDRAM timing and idle configuration block.
  Assumes inclusion by bare name; definitions only.
*/
`ifndef SDRAM_CFG_REGS_SVH
`define SDRAM_CFG_REGS_SVH
// register indexes, byte address is four times the index
`define IDX_CONTROL 14'h0400
`define IDX_INT_STATUS 14'h0402
`define IDX_INT_MASK 14'h0404
`define IDX_GEOMETRY 14'h0408
`define IDX_REF_INTERVAL 14'h0410
`define IDX_LATE_LIMIT 14'h0412
`define IDX_IDLE_CMD 14'h0420
`define IDX_IDLE_ADDR 14'h0422
// reset values
`define RST_CONTROL 16'h0000
`define RST_GEOMETRY 16'h0130
`define RST_REF_INTERVAL 16'h0400
`define RST_LATE_LIMIT 16'h0004
`define RST_IDLE_CMD 16'h001F
`define RST_IDLE_ADDR 16'h0000
// writable bits, the rest read as zero
`define MASK_CONTROL 16'h8001
`define MASK_INT 16'h0001
`define MASK_GEOMETRY 16'h07FF
`define MASK_IDLE_CMD 16'h001F
`define MASK_IDLE_ADDR 16'h0FFF
// field positions
`define CTL_EN 0
`define STS_LATE 0
`define GEO_COL_HI 1
`define GEO_COL_LO 0
`define GEO_CL 2
`define GEO_RC_HI 4
`define GEO_RC_LO 3
`define GEO_CP_HI 6
`define GEO_CP_LO 5
`define GEO_PC_HI 8
`define GEO_PC_LO 7
`define GEO_RS_HI 10
`define GEO_RS_LO 9
`define IDL_CAS 0
`define IDL_RAS 1
`define IDL_WE 2
`define IDL_BS_HI 4
`define IDL_BS_LO 3
`define IDL_ADDR_HI 11
// delay codes in clock cycles
`define DLY_CODE0 4'h4
`define RC_CODE1 4'h2
`define RS_CODE0 4'hF
`define RS_CODE2 4'h3
`define RS_CODE3 4'h7
`define GAP_SAT 4'hF
// column masks for 256, 512 and 1024 columns
`define COLMASK_256 12'h00FF
`define COLMASK_512 12'h01FF
`define COLMASK_1024 12'h03FF
// bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// *** sdram_cfg_pkg.sv ***
/*
  Types of the SDRAM timing and idle configuration block: command
  codes and the state records of its three modules.
  Assumes nothing of its surroundings.
*/
package sdram_cfg_pkg;
  typedef enum logic [1:0] {
    op_activate, op_read, op_write, op_precharge
  } mem_op_e;

  typedef struct packed {
    logic aw_got;
    logic [15:0] awaddr;
    logic w_got;
    logic [15:0] wdata;
    logic [1:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic ar_got;
    logic [15:0] araddr;
    logic rvalid;
    logic [15:0] rdata;
    logic [1:0] rresp;
  } axil_s;

  typedef struct packed {
    logic [15:0] cyc;
    logic [15:0] pend;
    logic late;
  } refresh_s;

  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] geometry;
    logic [15:0] ref_interval;
    logic [15:0] late_limit;
    logic [15:0] idle_cmd;
    logic [15:0] idle_addr;
    logic [15:0] int_status;
    logic [15:0] int_mask;
    logic live;
    logic cas_n;
    logic ras_n;
    logic we_n;
    logic [1:0] bs;
    logic [11:0] addr;
    logic [3:0][3:0] gap;
    logic row_open;
    logic [2:0] rd_pipe;
    logic irq;
  } ctrl_s;
endpackage

// *** sdram_cfg_axil.sv ***
/*
  AXI4-Lite slave that turns bus transfers into one-cycle register
  write and read strokes with 14-bit word indexes.
  Assumes the register owner answers hit and read data combinationally.
*/
`timescale 1ns/1ns
`include "sdram_cfg_regs.svh"
module sdram_cfg_axil (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [15:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [15:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic wr_go,
  output logic [13:0] wr_idx,
  output logic [15:0] wr_data,
  output logic [1:0] wr_be,
  input wire logic wr_hit,
  output logic rd_go,
  output logic [13:0] rd_idx,
  input wire logic [15:0] rd_data,
  input wire logic rd_hit
);
  sdram_cfg_pkg::axil_s st_ff;
  sdram_cfg_pkg::axil_s nxt_st;

  // channel readiness and strokes toward the register file
  assign awready = ~st_ff.aw_got & ~st_ff.bvalid;
  assign wready = ~st_ff.w_got & ~st_ff.bvalid;
  assign arready = ~st_ff.ar_got & ~st_ff.rvalid;
  assign wr_go = st_ff.aw_got & st_ff.w_got & ~st_ff.bvalid;
  assign rd_go = st_ff.ar_got & ~st_ff.rvalid;
  assign wr_idx = st_ff.awaddr[15:2];
  assign rd_idx = st_ff.araddr[15:2];
  assign wr_data = st_ff.wdata;
  assign wr_be = st_ff.wstrb;
  assign bvalid = st_ff.bvalid;
  assign bresp = st_ff.bresp;
  assign rvalid = st_ff.rvalid;
  assign rresp = st_ff.rresp;
  assign rdata = {16'h0000, st_ff.rdata};

  // address and data are taken in either order, answer follows both
  always_comb begin
    nxt_st = st_ff;
    if (awvalid && awready) begin
      nxt_st.aw_got = 1'b1;
      nxt_st.awaddr = awaddr;
    end
    if (wvalid && wready) begin
      nxt_st.w_got = 1'b1;
      nxt_st.wdata = wdata[15:0];
      nxt_st.wstrb = wstrb[1:0];
    end
    if (wr_go) begin
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = wr_hit ? `RESP_OKAY : `RESP_SLVERR;
    end
    if (st_ff.bvalid && bready) begin
      nxt_st.bvalid = 1'b0;
    end
    if (arvalid && arready) begin
      nxt_st.ar_got = 1'b1;
      nxt_st.araddr = araddr;
    end
    if (rd_go) begin
      nxt_st.ar_got = 1'b0;
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata = rd_hit ? rd_data : 16'h0000;
      nxt_st.rresp = rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end
    if (st_ff.rvalid && rready) begin
      nxt_st.rvalid = 1'b0;
    end
    if (!aresetn) begin
      nxt_st = '0;
    end
  end

  // state register
  always_ff @(posedge aclk) begin
    st_ff <= nxt_st;
  end
endmodule

// *** sdram_refresh_track.sv ***
/*
  Refresh interval counter and pending-refresh tracker with the
  lateness check.
  Assumes refresh_done pulses once per refresh put on the pins.
*/
`timescale 1ns/1ns
module sdram_refresh_track (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic enable,
  input wire logic [15:0] interval,
  input wire logic [15:0] late_limit,
  input wire logic refresh_done,
  output logic refresh_req,
  output logic [15:0] pending_count,
  output logic late_event
);
  sdram_cfg_pkg::refresh_s st_ff;
  sdram_cfg_pkg::refresh_s nxt_st;
  logic tick;

  assign refresh_req = st_ff.pend != 16'h0000;
  assign pending_count = st_ff.pend;
  assign late_event = st_ff.late;

  // interval elapsed, zero interval stops the schedule
  assign tick = enable && interval != 16'h0000 &&
    st_ff.cyc >= interval - 16'h0001;

  // cycle count, pending intervals and lateness pulse
  always_comb begin
    nxt_st = st_ff;
    nxt_st.late = 1'b0;
    if (!enable) begin
      nxt_st.cyc = 16'h0000;
      nxt_st.pend = 16'h0000;
    end else begin
      nxt_st.cyc = tick ? 16'h0000 : st_ff.cyc + 16'h0001;
      if (tick && !refresh_done && st_ff.pend != 16'hFFFF) begin
        nxt_st.pend = st_ff.pend + 16'h0001;
      end else if (!tick && refresh_done && st_ff.pend != 16'h0000) begin
        nxt_st.pend = st_ff.pend - 16'h0001;
      end
      nxt_st.late = tick && late_limit != 16'h0000 &&
        nxt_st.pend >= late_limit;
    end
    if (!aresetn) begin
      nxt_st = '0;
    end
  end

  // state register
  always_ff @(posedge aclk) begin
    st_ff <= nxt_st;
  end
endmodule

// *** mem_model.sv ***
/*
  far-side sdram model: decodes the command pins and counts refreshes.
  assumes the pins change only just after rising edges of aclk.
*/
`timescale 1ns/1ns
module mem_model (
  input wire logic aclk,
  input wire logic cas_n,
  input wire logic ras_n,
  input wire logic we_n,
  output int refreshes
);
  // count refresh commands, row and column strobe low with write high
  initial refreshes = 0;
  always @(posedge aclk) begin
    if (!ras_n && !cas_n && we_n) refreshes <= refreshes + 1;
  end
endmodule

// *** testbench.sv ***
/*
  top bench: register access, command port, refresh and idle pins.
  assumes every bus or command answer comes; only the hang guard ends a wait.
*/
`timescale 1ns/1ns
`include "sdram_cfg_regs.svh"
module testbench;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, cmd_valid = 0, awready, wready, bvalid;
  logic arready, rvalid, cmd_ready, read_capture, irq;
  logic mem_column_strobe_n, mem_row_strobe_n, mem_write_strobe_n;
  logic [15:0] awaddr = 0, araddr = 0, q;
  logic [31:0] wdata = 0, rdata;
  logic [3:0] wstrb = 4'h3;
  logic [1:0] bresp, rresp, mem_bank_select, r;
  logic [11:0] mem_address_bus, cmd_addr = 0;
  sdram_cfg_pkg::mem_op_e cmd_op = sdram_cfg_pkg::op_activate;
  int num_errors = 0, compares = 0, cycles = 0, refreshes;

  // clock of 100 ns
  always #50 aclk = ~aclk;

  sdram_timing_idle_config sdram_timing_idle_config_i (.aclk, .aresetn,
    .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .cmd_valid, .cmd_ready, .cmd_op, .cmd_bank(2'h0), .cmd_addr,
    .mem_column_strobe_n, .mem_row_strobe_n, .mem_write_strobe_n,
    .mem_bank_select, .mem_address_bus, .read_capture, .irq);
  mem_model mem_model_i (.aclk, .cas_n(mem_column_strobe_n),
    .ras_n(mem_row_strobe_n), .we_n(mem_write_strobe_n), .refreshes);

  task automatic conclude;
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] e,
    input logic [15:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  // one axi-lite write or read; each channel released once taken
  task automatic bus(input logic w, input logic [15:0] a,
    input logic [15:0] d, output logic [15:0] rq, output logic [1:0] rr);
    logic ta, tw, tb, tr, tv;
    @(posedge aclk);
    awaddr <= a;
    araddr <= a;
    wdata <= {16'h0000, d};
    awvalid <= w;
    wvalid <= w;
    bready <= w;
    arvalid <= !w;
    rready <= !w;
    forever begin
      @(negedge aclk);
      if (!(awvalid || wvalid || bready || arvalid || rready)) break;
      ta = awready;
      tw = wready;
      tb = bvalid && bready;
      tr = arready;
      tv = rvalid && rready;
      if (tb) rr = bresp;
      if (tv) rr = rresp;
      if (tv) rq = rdata[15:0];
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
      if (tr) arvalid <= 1'b0;
      if (tv) rready <= 1'b0;
    end
  endtask

  task automatic wr(input logic [13:0] i, input logic [15:0] d);
    bus(1'b1, {i, 2'b00}, d, q, r);
    chk("write resp", {14'h0, `RESP_OKAY}, {14'h0, r});
  endtask

  task automatic rd(input logic [13:0] i, input logic [15:0] e);
    bus(1'b0, {i, 2'b00}, 16'h0000, q, r);
    chk($sformatf("register %h", i), e, q);
  endtask

  // command port: hold valid until the edge where ready is seen
  task automatic cmd(input sdram_cfg_pkg::mem_op_e op, input logic [11:0] a);
    @(posedge aclk);
    cmd_op <= op;
    cmd_addr <= a;
    cmd_valid <= 1'b1;
    forever begin
      @(negedge aclk);
      if (cmd_ready === 1'b1) break;
    end
    @(posedge aclk);
    cmd_valid <= 1'b0;
  endtask

  task automatic pins(input logic [15:0] c, input logic [11:0] a);
    chk("cmd pins", c, {11'h000, mem_bank_select, mem_write_strobe_n,
      mem_row_strobe_n, mem_column_strobe_n});
    chk("address pins", {4'h0, a}, {4'h0, mem_address_bus});
  endtask

  // hang guard
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors++;
      conclude();
    end
  end

  // main sequence
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`IDX_GEOMETRY, 16'h0130);
    rd(`IDX_REF_INTERVAL, 16'h0400);
    rd(`IDX_IDLE_CMD, 16'h001F);
    pins(16'h001F, 12'h000);
    wr(`IDX_IDLE_CMD, 16'hFFEA);
    wr(`IDX_IDLE_ADDR, 16'hFABC);
    repeat (2) @(negedge aclk);
    pins(16'h000A, 12'hABC);
    rd(`IDX_IDLE_ADDR, 16'h0ABC);
    bus(1'b0, 16'h1004, 16'h0000, q, r);
    chk("unmapped resp", {14'h0, `RESP_SLVERR}, {14'h0, r});
    wr(`IDX_GEOMETRY, 16'h050D);
    rd(`IDX_GEOMETRY, 16'h050D);
    wr(`IDX_CONTROL, 16'h0001);
    cmd(sdram_cfg_pkg::op_activate, 12'h123);
    cmd(sdram_cfg_pkg::op_read, 12'hFFF);
    @(negedge aclk);
    pins(16'h0006, 12'h1FF);
    @(negedge aclk);
    chk("capture early", 16'h0000, {15'h0, read_capture});
    @(negedge aclk);
    chk("capture", 16'h0001, {15'h0, read_capture});
    wr(`IDX_LATE_LIMIT, 16'h0002);
    wr(`IDX_REF_INTERVAL, 16'h0010);
    repeat (60) @(negedge aclk);
    chk("irq masked", 16'h0000, {15'h0, irq});
    chk("refresh held", 16'h0000, refreshes[15:0]);
    wr(`IDX_INT_MASK, 16'h0001);
    repeat (2) @(negedge aclk);
    chk("irq", 16'h0001, {15'h0, irq});
    cmd(sdram_cfg_pkg::op_precharge, 12'h400);
    repeat (40) @(negedge aclk);
    chk("refresh", 16'h0001, {15'h0, refreshes > 0});
    rd(`IDX_INT_STATUS, 16'h0001);
    repeat (40) @(negedge aclk);
    rd(`IDX_INT_STATUS, 16'h0000);
    chk("irq cleared", 16'h0000, {15'h0, irq});
    wr(`IDX_CONTROL, 16'h0000);
    repeat (2) @(negedge aclk);
    pins(16'h000A, 12'hABC);
    chk("cmd ready", 16'h0000, {15'h0, cmd_ready});
    conclude();
  end
endmodule
